// file: shared/ivc_cfg.svh
// Constants of the interrupt vector controller: table addresses, widths, counts.
// Assumes inclusion by bare name from every file that needs a figure.
// Operation
// - All peripheral requests are merged into one request line toward the core.
// - The table holds six non-maskable trap vectors plus up to 246 interrupt source vectors.
// - The primary vector table starts in program memory at address 000004h.
// - Each table entry is a 24-bit handler start address returned to the core.
// - A lower vector position has higher natural priority, vector 0 beating all others.
// - Seven selectable priority levels exist and ties within a level go by vector order.
// - Entry and return latencies are fixed whatever source is being served.
// - The alternate table is used only with a boot segment, the fuse programmed and enable 1.
// - With the alternate table on, every interrupt and trap takes its vector from it.
// - The alternate table begins at the start of the last boot segment page.
// - The alternate table cannot be on unless the boot segment is at least 2 pages long.
// - Both tables carry the boot segment code protection.
// - Reset bypasses the controller and leaves the core starting at address 0x000000.
`ifndef IVC_CFG_SVH
`define IVC_CFG_SVH

`define IVC_ADDR_W        24
`define IVC_VEC_W         8
`define IVC_LVL_W         4
`define IVC_PRIO_W        3
`define IVC_PROT_W        2
`define IVC_LIMIT_W       13
`define IVC_NUM_TRAPS     6
`define IVC_NUM_SOURCES   246
`define IVC_PRIMARY_BASE  24'h000004
`define IVC_RESET_ADDR    24'h000000
`define IVC_VEC_STEP_SH   1
`define IVC_PAGE_SHIFT    11
`define IVC_MIN_BOOT_PGS  13'h0002
`define IVC_TRAP_LEVEL    4'h8
`define IVC_FETCH_CYCLES  2
`define IVC_RETURN_CYCLES 1

`endif

// file: shared/ivc_pkg.sv
// Types of the interrupt vector controller.
// Assumes ivc_cfg.svh is on the include path.
`include "ivc_cfg.svh"
package ivc_pkg;

    typedef logic [`IVC_ADDR_W-1:0] prog_addr_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_FETCH = 4'h2,
        ST_LOAD  = 4'h4,
        ST_RET   = 4'h8
    } ctl_state_t;

endpackage

// file: logic/priority_arbiter.sv
// Picks the pending vector of highest level; among equal levels the lowest index.
// Assumes a level of zero means the vector takes no part.
`timescale 1ns/100ps
module priority_arbiter #(
    parameter int N  = 252,
    parameter int LW = 4,
    parameter int IW = 8
) (
    // Candidates
    input  wire logic [N-1:0]    pend_in,
    input  wire logic [N*LW-1:0] lvl_in,
    // Winner
    output logic                 any_out,
    output logic [IW-1:0]        idx_out,
    output logic [LW-1:0]        lvl_out
);

    // Scan from the top so a lower index overwrites an equal level
    always_comb begin
        any_out = 1'b0;
        idx_out = '0;
        lvl_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_in[i] && (lvl_in[i*LW +: LW] != '0) &&
                (lvl_in[i*LW +: LW] >= lvl_out)) begin
                any_out = 1'b1;
                idx_out = IW'(i);
                lvl_out = lvl_in[i*LW +: LW];
            end
        end
    end

endmodule

// file: logic/interrupt_vector_controller.sv
// Interrupt vector controller: pending flags, arbitration, table select, vector fetch.
// Assumes requests, traps and core handshakes come from logic on mclk_in, and that
// program memory returns vec_data_in one cycle after fetch_en_out.
`timescale 1ns/100ps
`include "ivc_cfg.svh"
module interrupt_vector_controller #(
    parameter int NUM_SOURCES = `IVC_NUM_SOURCES
) (
    // Clock and reset
    input  wire logic                                mclk_in,
    input  wire logic                                rst_in,
    // Requests
    input  wire logic [`IVC_NUM_TRAPS-1:0]           trap_in,
    input  wire logic [NUM_SOURCES-1:0]              src_req_in,
    input  wire logic [NUM_SOURCES-1:0]              src_enable_in,
    input  wire logic [NUM_SOURCES*`IVC_PRIO_W-1:0]  src_prio_in,
    // Core handshake
    input  wire logic [`IVC_PRIO_W-1:0]              cpu_prio_in,
    input  wire logic                                irq_ack_in,
    input  wire logic                                irq_return_in,
    output logic                                     irq_req_out,
    output logic [`IVC_VEC_W-1:0]                    irq_vector_out,
    output logic [`IVC_LVL_W-1:0]                    irq_level_out,
    output logic                                     return_done_out,
    // Table configuration
    input  wire logic                                boot_seg_defined_in,
    input  wire logic                                alt_table_config_fuse_in,
    input  wire logic                                alt_table_enable_in,
    input  wire logic [`IVC_LIMIT_W-1:0]             boot_segment_limit_in,
    input  wire logic [`IVC_PROT_W-1:0]              boot_code_prot_in,
    output logic                                     alt_table_active_out,
    // Program memory
    output logic                                     fetch_en_out,
    output logic [`IVC_ADDR_W-1:0]                   fetch_addr_out,
    output logic [`IVC_PROT_W-1:0]                   fetch_prot_out,
    input  wire logic [`IVC_ADDR_W-1:0]              vec_data_in,
    output logic [`IVC_ADDR_W-1:0]                   handler_addr_out,
    output logic                                     handler_valid_out
);

    localparam int NT = `IVC_NUM_TRAPS;
    localparam int NV = NT + NUM_SOURCES;
    localparam int LW = `IVC_LVL_W;
    localparam int VW = `IVC_VEC_W;

    // ----------------------------------------------------------------
    // Table entry address
    // ----------------------------------------------------------------
    function automatic ivc_pkg::prog_addr_t entry_addr(input ivc_pkg::prog_addr_t base,
                                                       input logic [VW-1:0] vec);
        ivc_pkg::prog_addr_t ofs;
        ofs = ivc_pkg::prog_addr_t'(vec) << `IVC_VEC_STEP_SH;
        return base + ofs;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    ivc_pkg::ctl_state_t state_q, state_d;
    logic [NV-1:0]        pend_q, pend_d;
    logic                 req_q, req_d;
    logic [VW-1:0]        vec_q, vec_d;
    logic [LW-1:0]        lvl_q, lvl_d;
    ivc_pkg::prog_addr_t  faddr_q, faddr_d;
    logic [`IVC_PROT_W-1:0] prot_q, prot_d;
    ivc_pkg::prog_addr_t  handler_q, handler_d;
    logic                 hvalid_q, hvalid_d;

    // ----------------------------------------------------------------
    // Pending flags and levels
    // ----------------------------------------------------------------
    wire logic [NV-1:0]    set_all = {src_req_in, trap_in};
    wire logic [NV-1:0]    one_hot = NV'(1);
    wire logic             st_idle = (state_q == ivc_pkg::ST_IDLE);
    wire logic             ack_take = irq_ack_in && req_q && st_idle;
    wire logic [NV-1:0]    clr_mask = ack_take ? (one_hot << vec_q) : '0;
    wire logic [NV*LW-1:0] lvl_all;

    // Set wins over a clear in the same cycle
    assign pend_d = set_all | (pend_q & ~clr_mask);

    genvar g;
    generate
        for (g = 0; g < NV; g++) begin : g_lvl
            if (g < NT) begin : g_trap
                assign lvl_all[g*LW +: LW] = `IVC_TRAP_LEVEL;
            end else begin : g_src
                assign lvl_all[g*LW +: LW] = src_enable_in[g-NT] ?
                    {1'b0, src_prio_in[(g-NT)*`IVC_PRIO_W +: `IVC_PRIO_W]} : '0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    logic          win_any;
    logic [VW-1:0] win_idx;
    logic [LW-1:0] win_lvl;

    priority_arbiter #(
        .N  (NV),
        .LW (LW),
        .IW (VW)
    ) u_arb (
        .pend_in (pend_q),
        .lvl_in  (lvl_all),
        .any_out (win_any),
        .idx_out (win_idx),
        .lvl_out (win_lvl)
    );

    wire logic above_cpu = win_any && (win_lvl > {1'b0, cpu_prio_in});
    assign req_d = above_cpu && st_idle && !ack_take;
    assign vec_d = win_idx;
    assign lvl_d = win_lvl;

    // ----------------------------------------------------------------
    // Table select
    // ----------------------------------------------------------------
    wire ivc_pkg::prog_addr_t limit_ext =
        ivc_pkg::prog_addr_t'(boot_segment_limit_in);
    wire logic big_enough = (boot_segment_limit_in >= `IVC_MIN_BOOT_PGS);
    wire logic alt_on = boot_seg_defined_in && alt_table_config_fuse_in &&
                        alt_table_enable_in && big_enough;
    wire ivc_pkg::prog_addr_t alt_base =
        (limit_ext - ivc_pkg::prog_addr_t'(1)) << `IVC_PAGE_SHIFT;
    wire ivc_pkg::prog_addr_t table_base = alt_on ? alt_base : `IVC_PRIMARY_BASE;

    assign faddr_d = ack_take ? entry_addr(table_base, vec_q) : faddr_q;
    assign prot_d  = ack_take ? boot_code_prot_in : prot_q;

    // ----------------------------------------------------------------
    // Entry and return sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ivc_pkg::ST_IDLE: begin
                if (ack_take) begin
                    state_d = ivc_pkg::ST_FETCH;
                end else if (irq_return_in) begin
                    state_d = ivc_pkg::ST_RET;
                end
            end
            ivc_pkg::ST_FETCH: state_d = ivc_pkg::ST_LOAD;
            ivc_pkg::ST_LOAD:  state_d = ivc_pkg::ST_IDLE;
            ivc_pkg::ST_RET:   state_d = ivc_pkg::ST_IDLE;
            default:           state_d = ivc_pkg::ST_IDLE;
        endcase
    end

    wire logic st_load = (state_q == ivc_pkg::ST_LOAD);
    assign handler_d = st_load ? vec_data_in : handler_q;
    assign hvalid_d  = st_load;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= ivc_pkg::ST_IDLE;
            pend_q    <= '0;
            req_q     <= 1'b0;
            vec_q     <= '0;
            lvl_q     <= '0;
            faddr_q   <= `IVC_RESET_ADDR;
            prot_q    <= '0;
            handler_q <= `IVC_RESET_ADDR;
            hvalid_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            pend_q    <= pend_d;
            req_q     <= req_d;
            vec_q     <= vec_d;
            lvl_q     <= lvl_d;
            faddr_q   <= faddr_d;
            prot_q    <= prot_d;
            handler_q <= handler_d;
            hvalid_q  <= hvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign irq_req_out          = req_q;
    assign irq_vector_out       = vec_q;
    assign irq_level_out        = lvl_q;
    assign return_done_out      = (state_q == ivc_pkg::ST_RET);
    assign alt_table_active_out = alt_on;
    assign fetch_en_out         = (state_q == ivc_pkg::ST_FETCH);
    assign fetch_addr_out       = faddr_q;
    assign fetch_prot_out       = prot_q;
    assign handler_addr_out     = handler_q;
    assign handler_valid_out    = hvalid_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_pend_set_wins: assert property (@(posedge mclk_in) disable iff (rst_in)
        (ack_take && set_all[vec_q]) |=> pend_q[$past(vec_q)])
        else $error("pending flag lost when set and clear coincide");

    a_req_above_cpu: assert property (@(posedge mclk_in) disable iff (rst_in)
        irq_req_out |-> $past(win_lvl > {1'b0, cpu_prio_in}) && $past(win_any))
        else $error("request raised without a level above the core");

    a_ack_fetch_gap: assert property (@(posedge mclk_in) disable iff (rst_in)
        ack_take |=> fetch_en_out ##1 !fetch_en_out ##1 handler_valid_out)
        else $error("entry latency is not fixed");

    a_handler_value: assert property (@(posedge mclk_in) disable iff (rst_in)
        fetch_en_out ##1 1'b1 |=> handler_addr_out == $past(vec_data_in))
        else $error("handler address does not match fetched entry");

    a_alt_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
        alt_table_active_out |-> (boot_seg_defined_in && alt_table_config_fuse_in &&
                                  alt_table_enable_in))
        else $error("alternate table active without all its conditions");

    a_alt_min_pages: assert property (@(posedge mclk_in) disable iff (rst_in)
        (boot_segment_limit_in < `IVC_MIN_BOOT_PGS) |-> !alt_table_active_out)
        else $error("alternate table active in a too short boot segment");

    a_primary_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
        (ack_take && !alt_on) |=>
        fetch_addr_out == `IVC_PRIMARY_BASE + ivc_pkg::prog_addr_t'({$past(vec_q), 1'b0}))
        else $error("primary table entry address wrong");

    a_alt_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
        (ack_take && alt_on) |=>
        fetch_addr_out == $past(alt_base) + ivc_pkg::prog_addr_t'({$past(vec_q), 1'b0}))
        else $error("alternate table entry address wrong");

    a_return_fixed: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_idle && !ack_take && irq_return_in) |=> return_done_out ##1 !return_done_out)
        else $error("return latency is not fixed");

    a_trap_first: assert property (@(posedge mclk_in) disable iff (rst_in)
        (pend_q[0] && st_idle && !ack_take) |=> irq_req_out && irq_vector_out == '0)
        else $error("vector 0 did not win");

endmodule

// file: testbench/core_mem_model.sv
// Partner model: processor core that accepts requests, and program memory holding the tables.
// Assumes the controller samples vec_data_in one cycle after fetch_en_out, all on mclk_in.
`timescale 1ns/100ps
module core_mem_model (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // Bench control
    input  wire logic        ack_enable_in,
    input  wire logic [3:0]  ack_delay_in,
    // Controller side
    input  wire logic        irq_req_in,
    input  wire logic        fetch_en_in,
    input  wire logic [23:0] fetch_addr_in,
    output logic             irq_ack_out,
    output logic [23:0]      vec_data_out
);
    logic [3:0] wait_q;
    logic       hit;

    assign hit = (wait_q == ack_delay_in);

    // --------------------------------
    // Core: one-cycle accept after a chosen wait
    // --------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_ack_out <= 1'b0;
            wait_q      <= 4'h0;
        end else if (irq_req_in && !irq_ack_out && ack_enable_in) begin
            irq_ack_out <= hit;
            wait_q      <= hit ? 4'h0 : wait_q + 4'h1;
        end else begin
            irq_ack_out <= 1'b0;
            wait_q      <= 4'h0;
        end
    end

    // --------------------------------
    // Memory: every entry, used or not, holds a handler address
    // --------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in)
            vec_data_out <= 24'h000000;
        else if (fetch_en_in)
            vec_data_out <= fetch_addr_in ^ 24'h5A5A5A;
        else
            vec_data_out <= ~vec_data_out;
    end
endmodule

// file: testbench/tb_interrupt_vector_controller.sv
// Testbench of the interrupt vector controller: table rows, ties, masking, return, reset.
// Assumes core_mem_model answers accepts and vector fetches.
`timescale 1ns/100ps
module tb_interrupt_vector_controller;
    typedef struct packed {
        logic [7:0]  vec;
        logic [2:0]  prio;
        logic [2:0]  cfg;
        logic [12:0] lim;
        logic [1:0]  prot;
        logic        alt;
        logic [23:0] entry;
    } row_t;

    // --------------------------------
    // Rows: vector, priority, table setup, expected table state and entry
    // --------------------------------
    row_t rows [7] = '{
        '{8'h00, 3'h0, 3'h0, 13'h0000, 2'h0, 1'b0, 24'h000004},
        '{8'h05, 3'h0, 3'h7, 13'h0002, 2'h1, 1'b1, 24'h00080A},
        '{8'h06, 3'h1, 3'h7, 13'h0001, 2'h2, 1'b0, 24'h000010},
        '{8'hFB, 3'h7, 3'h3, 13'h0004, 2'h3, 1'b0, 24'h0001FA},
        '{8'h64, 3'h3, 3'h5, 13'h0004, 2'h0, 1'b0, 24'h0000CC},
        '{8'h14, 3'h2, 3'h6, 13'h0004, 2'h1, 1'b0, 24'h00002C},
        '{8'h07, 3'h6, 3'h7, 13'h1FFF, 2'h2, 1'b1, 24'hFFF00E}
    };
    logic         mclk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic [5:0]   trap_in = '0;
    logic [245:0] src_req_in = '0;
    logic [245:0] src_enable_in = '0;
    logic [737:0] src_prio_in = '0;
    logic [2:0]   cpu_prio_in = '0;
    logic         irq_return_in = 1'b0;
    logic         boot_seg_defined_in = 1'b0;
    logic         alt_table_config_fuse_in = 1'b0;
    logic         alt_table_enable_in = 1'b0;
    logic [12:0]  boot_segment_limit_in = '0;
    logic [1:0]   boot_code_prot_in = '0;
    logic         ack_en = 1'b0;
    logic [3:0]   ack_dly = '0;
    logic         irq_ack_in, irq_req_out, return_done_out, alt_table_active_out;
    logic         fetch_en_out, handler_valid_out;
    logic [7:0]   irq_vector_out;
    logic [3:0]   irq_level_out;
    logic [1:0]   fetch_prot_out;
    logic [23:0]  fetch_addr_out, vec_data_in, handler_addr_out;
    int           errors = 0;
    int           checks_done = 0;
    row_t         r;

    interrupt_vector_controller uut (
        .mclk_in, .rst_in, .trap_in, .src_req_in, .src_enable_in, .src_prio_in,
        .cpu_prio_in, .irq_ack_in, .irq_return_in, .irq_req_out, .irq_vector_out,
        .irq_level_out, .return_done_out, .boot_seg_defined_in, .alt_table_config_fuse_in,
        .alt_table_enable_in, .boot_segment_limit_in, .boot_code_prot_in,
        .alt_table_active_out, .fetch_en_out, .fetch_addr_out, .fetch_prot_out,
        .vec_data_in, .handler_addr_out, .handler_valid_out
    );

    core_mem_model model (
        .mclk_in, .rst_in, .ack_enable_in(ack_en), .ack_delay_in(ack_dly),
        .irq_req_in(irq_req_out), .fetch_en_in(fetch_en_out), .fetch_addr_in(fetch_addr_out),
        .irq_ack_out(irq_ack_in), .vec_data_out(vec_data_in)
    );

    initial forever #50 mclk_in = ~mclk_in;

    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic complete_run();
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic raise(input int a, input int b);
        @(posedge mclk_in);
        if (a < 6) trap_in[a] <= 1'b1;
        else src_req_in[a - 6] <= 1'b1;
        if (b > a) src_req_in[b - 6] <= 1'b1;
        @(posedge mclk_in);
        trap_in <= '0;
        src_req_in <= '0;
    endtask

    task automatic serve(input logic [23:0] entry, input logic [1:0] prot);
        int n;
        n = 0;
        @(posedge mclk_in);
        ack_en <= 1'b1;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
            if (n > 30) begin
                errors++;
                $display("ERROR %0t: no accept seen", $time);
                complete_run();
            end
        end while (irq_ack_in !== 1'b1);
        @(posedge mclk_in);
        ack_en <= 1'b0;
        #1;
        check(fetch_en_out, 1'b1);
        check(fetch_addr_out, entry);
        check(fetch_prot_out, prot);
        repeat (2) @(posedge mclk_in);
        #1;
        check(handler_valid_out, 1'b1);
        check(handler_addr_out, entry ^ 24'h5A5A5A);
    endtask

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            @(posedge mclk_in);
            {boot_seg_defined_in, alt_table_config_fuse_in, alt_table_enable_in} <= r.cfg;
            boot_segment_limit_in <= r.lim;
            boot_code_prot_in <= r.prot;
            ack_dly <= (i % 2 == 1) ? 4'h3 : 4'h0;
            if (r.vec > 8'h05) begin
                src_enable_in[r.vec - 6] <= 1'b1;
                src_prio_in[3 * (r.vec - 6) +: 3] <= r.prio;
            end
            raise(r.vec, 0);
            @(posedge mclk_in);
            #1;
            check(irq_req_out, 1'b1);
            check(irq_vector_out, r.vec);
            check(irq_level_out, r.vec < 6 ? 4'h8 : {1'b0, r.prio});
            check(alt_table_active_out, r.alt);
            serve(r.entry, r.prot);
        end
        // Equal levels, core priority masking and a disabled source
        @(posedge mclk_in);
        {boot_seg_defined_in, alt_table_config_fuse_in, alt_table_enable_in} <= 3'h0;
        boot_code_prot_in <= 2'h0;
        cpu_prio_in <= 3'h4;
        src_enable_in[3] <= 1'b1;
        src_prio_in[11:9] <= 3'h4;
        src_enable_in[10] <= 1'b1;
        src_prio_in[32:30] <= 3'h4;
        src_enable_in[30] <= 1'b0;
        src_prio_in[92:90] <= 3'h7;
        raise(16, 16);
        raise(9, 36);
        repeat (2) @(posedge mclk_in);
        #1;
        check(irq_req_out, 1'b0);
        @(posedge mclk_in);
        cpu_prio_in <= 3'h3;
        repeat (2) @(posedge mclk_in);
        #1;
        check(irq_vector_out, 8'h09);
        serve(24'h000016, 2'h0);
        serve(24'h000024, 2'h0);
        @(posedge mclk_in);
        src_enable_in[30] <= 1'b1;
        cpu_prio_in <= 3'h7;
        repeat (2) @(posedge mclk_in);
        #1;
        check(irq_req_out, 1'b0);
        @(posedge mclk_in);
        cpu_prio_in <= 3'h6;
        repeat (2) @(posedge mclk_in);
        #1;
        check(irq_vector_out, 8'h24);
        serve(24'h00004C, 2'h0);
        // Request held high across its own accept: the set beats the clear
        @(posedge mclk_in);
        src_req_in[30] <= 1'b1;
        serve(24'h00004C, 2'h0);
        @(posedge mclk_in);
        src_req_in[30] <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        check(irq_req_out, 1'b1);
        check(irq_vector_out, 8'h24);
        serve(24'h00004C, 2'h0);
        // Return pulse while idle
        @(posedge mclk_in);
        irq_return_in <= 1'b1;
        @(posedge mclk_in);
        irq_return_in <= 1'b0;
        #1;
        check(return_done_out, 1'b1);
        @(posedge mclk_in);
        #1;
        check(return_done_out, 1'b0);
        // Reset in mid-run with a request pending
        raise(2, 0);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        #1;
        check(irq_req_out, 1'b0);
        check(handler_addr_out, 24'h000000);
        check(fetch_addr_out, 24'h000000);
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
        check(irq_req_out, 1'b0);
        complete_run();
    end
endmodule
